/* File: rtl/arcc_pkg.sv */
/*
  Shared constants for the audio route core control block: register
  offsets, field layouts, reset values and rate divisors.
  Assumes an 8-bit control port with 16-bit register addresses.
*/
`default_nettype none
package arcc_pkg;
  // ===========================================
  // Register offsets
  localparam logic [15:0] OFS_FRAME_RATE = 16'h40EB;
  localparam logic [15:0] OFS_CAPTURE_ROUTE = 16'h40F3;
  localparam logic [15:0] OFS_PIN_FUNC = 16'h40F4;
  localparam logic [15:0] OFS_PROC_RUN = 16'h40F6;
  localparam logic [15:0] OFS_PORT_RATE = 16'h40F8;
  // ===========================================
  // Field widths and reset values
  localparam int ROUTE_W = 4;
  localparam int PIN_W = 4;
  localparam int FRAME_W = 4;
  localparam int PORT_W = 3;
  localparam logic [3:0] RST_ROUTE = 4'h0;
  localparam logic [3:0] RST_PIN_FUNC = 4'h0;
  localparam logic [3:0] RST_FRAME_RATE = 4'h0;
  localparam logic RST_RUN = 1'b0;
  localparam logic [2:0] RST_PORT_RATE = 3'h0;
  localparam logic [3:0] ROUTE_VIA_PROC = 4'h0;
  localparam logic [3:0] FRAME_NONE_MIN = 4'hA;
  localparam logic [3:0] FRAME_IN_RATE = 4'h7;
  localparam logic [3:0] FRAME_OUT_RATE = 4'h8;
  // ===========================================
  // Pin positions in the pin function field
  localparam int PIN_FRAME_CLK = 3;
  localparam int PIN_BIT_CLK = 2;
  localparam int PIN_DATA_OUT = 1;
  localparam int PIN_DATA_IN = 0;
  // ===========================================
  // Timing: base rate counted in quarter periods
  localparam int CLK_HZ = 40000000;
  localparam int BASE_RATE_HZ = 48000;
  localparam int QTR_DIV = CLK_HZ / (4 * BASE_RATE_HZ);
  localparam int SYNC_STAGES = 3;

  // Port rate period in quarter base periods, 0 for reserved code 111
  function automatic logic [4:0] port_div(input logic [2:0] code);
    case (code)
      3'h0: port_div = 5'h04;
      3'h1: port_div = 5'h18;
      3'h2: port_div = 5'h10;
      3'h3: port_div = 5'h0C;
      3'h4: port_div = 5'h08;
      3'h5: port_div = 5'h06;
      3'h6: port_div = 5'h02;
      default: port_div = 5'h00;
    endcase
  endfunction

  // Processor frame period in quarter base periods, 0 for none
  function automatic logic [4:0] frame_div(input logic [3:0] code,
                                           input logic [2:0] port);
    case (code)
      4'h0: frame_div = 5'h02;
      4'h1: frame_div = 5'h04;
      4'h2: frame_div = 5'h06;
      4'h3: frame_div = 5'h08;
      4'h4: frame_div = 5'h0C;
      4'h5: frame_div = 5'h10;
      4'h6: frame_div = 5'h18;
      4'h7: frame_div = port_div(port);
      4'h8: frame_div = port_div(port);
      4'h9: frame_div = 5'h01;
      default: frame_div = 5'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: rtl/arcc_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`default_nettype none
module arcc_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage carries no reset, so it may map to RAM
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule // arcc_fifo
`default_nettype wire

/* File: rtl/arcc_core.sv */
/*
  Audio route core control: control registers, capture routing into
  serial output slots, pin function muxing, processor run and frame
  pulses, and serial port rate ticks.
  Assumes one 40 MHz clock, a register port on that clock, and
  serial pins arriving asynchronously.
*/
`default_nettype none
// Operation
// RULE_01: Route code zero sends converter samples through the processor to outputs.
// RULE_02: Odd codes with bit 3 clear bypass processor, left/right to slot halves.
// RULE_03: Odd codes with bit 3 set bypass processor and swap the halves.
// RULE_04: Even nonzero route codes are reserved; software avoids them.
// RULE_05: Each pin function bit set makes its pin a processor GPIO; reset 0.
// RULE_06: Bit 3 clear gives frame clock pin; bit 2 clear gives bit clock pin.
// RULE_07: Bit 1 clear makes its pin carry serial output data.
// RULE_08: Bit 0 clear makes its pin accept serial input data.
// RULE_09: Run bit 0 runs the processor when set, standby when clear; reset 0.
// RULE_10: Running processor advances only on delivery of a new frame.
// RULE_11: Before standby software writes frame rate none, waits 3 ms, clears run.
// RULE_12: To restart, software programs frame rate first, then writes run 0x01.
// RULE_13: Port rate code sets port rate from base rate; 111 reserved; reset 000.
// RULE_14: Software should keep port, processor and converter rates equal.
// RULE_15: Frame rate codes 1010 to 1111 issue no processor frame pulses.
module arcc_core #(
  parameter int SAMPLE_W = 24,
  parameter int FIFO_DEPTH = 8,
  parameter int QTR_CYCLES = arcc_pkg::QTR_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Converter samples
  input wire logic adc_valid,
  output logic adc_ready,
  input wire logic [SAMPLE_W-1:0] adc_left,
  input wire logic [SAMPLE_W-1:0] adc_right,
  // Processor side
  output logic proc_run,
  output logic proc_frame_start,
  output logic proc_in_valid,
  output logic [SAMPLE_W-1:0] proc_in_left,
  output logic [SAMPLE_W-1:0] proc_in_right,
  input wire logic proc_valid,
  output logic proc_ready,
  input wire logic [1:0] proc_slot,
  input wire logic [SAMPLE_W-1:0] proc_left,
  input wire logic [SAMPLE_W-1:0] proc_right,
  input wire logic [3:0] proc_gpio_out,
  output logic [3:0] proc_gpio_in,
  // Serial output stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_slot,
  output logic [SAMPLE_W-1:0] out_left,
  output logic [SAMPLE_W-1:0] out_right,
  output logic port_tick,
  // Serial port logic
  input wire logic sp_frame_clk,
  input wire logic sp_bit_clk,
  input wire logic sp_data_out,
  output logic sp_data_in,
  // Shared pins
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe
);
  localparam int FW = 2 + 2 * SAMPLE_W;

  // ===========================================
  // Registers
  logic [3:0] route_q, pin_func_q, frame_q;
  logic run_q;
  logic [2:0] port_q;
  logic [7:0] rdata_q;

  wire wr_route = reg_wr && (reg_addr == arcc_pkg::OFS_CAPTURE_ROUTE);
  wire wr_pin = reg_wr && (reg_addr == arcc_pkg::OFS_PIN_FUNC);
  wire wr_run = reg_wr && (reg_addr == arcc_pkg::OFS_PROC_RUN);
  wire wr_frame = reg_wr && (reg_addr == arcc_pkg::OFS_FRAME_RATE);
  wire wr_port = reg_wr && (reg_addr == arcc_pkg::OFS_PORT_RATE);

  // Reserved bits read as zero, unmapped reads give 0x00
  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == arcc_pkg::OFS_CAPTURE_ROUTE) ? {4'h0, route_q} :
    (reg_addr == arcc_pkg::OFS_PIN_FUNC) ? {4'h0, pin_func_q} :
    (reg_addr == arcc_pkg::OFS_PROC_RUN) ? {7'h00, run_q} :
    (reg_addr == arcc_pkg::OFS_FRAME_RATE) ? {4'h0, frame_q} :
    (reg_addr == arcc_pkg::OFS_PORT_RATE) ? {5'h00, port_q} : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      route_q <= arcc_pkg::RST_ROUTE;
      pin_func_q <= arcc_pkg::RST_PIN_FUNC; // RULE_05
      run_q <= arcc_pkg::RST_RUN; // RULE_09
      frame_q <= arcc_pkg::RST_FRAME_RATE;
      port_q <= arcc_pkg::RST_PORT_RATE; // RULE_13
      rdata_q <= 8'h00;
    end else begin
      if (wr_route) route_q <= reg_wdata[3:0];
      if (wr_pin) pin_func_q <= reg_wdata[3:0];
      if (wr_run) run_q <= reg_wdata[0];
      if (wr_frame) frame_q <= reg_wdata[3:0];
      if (wr_port) port_q <= reg_wdata[2:0];
      if (reg_rd) rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;

  // ===========================================
  // Rate ticks: quarter base period, then port and frame counters
  logic [15:0] qcnt_q;
  logic [4:0] pcnt_q, fcnt_q;
  wire q_tick = (qcnt_q == 16'(QTR_CYCLES - 1));
  wire [4:0] pdiv = arcc_pkg::port_div(port_q);
  wire [4:0] fdiv = arcc_pkg::frame_div(frame_q, port_q);
  // Zero divisor means reserved or none: counter keeps counting and wraps, no ticks
  wire p_hit = q_tick && (pdiv != 5'h00) && (pcnt_q == pdiv - 5'h01); // RULE_13
  wire f_hit = q_tick && (fdiv != 5'h00) && (fcnt_q == fdiv - 5'h01); // RULE_15

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qcnt_q <= '0;
      pcnt_q <= '0;
      fcnt_q <= '0;
    end else begin
      qcnt_q <= q_tick ? '0 : qcnt_q + 16'h0001;
      // Restart on a rate write so a stale count cannot overshoot
      if (wr_port || p_hit) pcnt_q <= '0;
      else if (q_tick) pcnt_q <= pcnt_q + 5'h01;
      if (wr_frame || wr_port || f_hit) fcnt_q <= '0;
      else if (q_tick) fcnt_q <= fcnt_q + 5'h01;
    end
  end

  assign port_tick = p_hit;
  assign proc_run = run_q;
  assign proc_frame_start = run_q && f_hit; // RULE_10

  // ===========================================
  // Capture routing
  wire via_proc = (route_q == arcc_pkg::ROUTE_VIA_PROC);
  wire bypass = route_q[0];
  wire swap = route_q[3];
  logic fin_valid, fin_ready;
  logic [FW-1:0] fin_data;
  logic pin_valid_q;
  logic [SAMPLE_W-1:0] pin_left_q, pin_right_q;

  // Samples go to the processor register only while it can take them
  wire proc_take = via_proc && (!pin_valid_q);
  assign adc_ready = via_proc ? proc_take : (bypass ? fin_ready : 1'b1);
  assign proc_ready = via_proc && fin_ready;
  assign fin_valid = via_proc ? proc_valid : (bypass && adc_valid); // RULE_01 RULE_02
  assign fin_data = via_proc ? {proc_slot, proc_left, proc_right} : // RULE_01
                    swap ? {route_q[2:1], adc_right, adc_left} : // RULE_03
                    {route_q[2:1], adc_left, adc_right}; // RULE_02

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_valid_q <= 1'b0;
      pin_left_q <= '0;
      pin_right_q <= '0;
    end else begin
      // Held one cycle for the processor input port
      pin_valid_q <= proc_take && adc_valid;
      if (proc_take && adc_valid) begin
        pin_left_q <= adc_left;
        pin_right_q <= adc_right;
      end
    end
  end
  assign proc_in_valid = pin_valid_q;
  assign proc_in_left = pin_left_q;
  assign proc_in_right = pin_right_q;

  logic [FW-1:0] fout_data;
  arcc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .in_data(fin_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fout_data)
  );
  assign out_slot = fout_data[FW-1 -: 2];
  assign out_left = fout_data[2*SAMPLE_W-1 -: SAMPLE_W];
  assign out_right = fout_data[SAMPLE_W-1:0];

  // ===========================================
  // Pin functions, inputs through three flops then a filter flop that updates when the last two agree
  logic [3:0] s1_q, s2_q, s3_q, pin_in_q, po_q, poe_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_in_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) pin_in_q[i] <= s3_q[i];
      end
    end
  end

  wire [3:0] sp_drive = {sp_frame_clk, sp_bit_clk, sp_data_out, 1'b0};
  wire [3:0] sp_oe = 4'hE;
  wire [3:0] po_d, poe_d;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      assign po_d[g] = pin_func_q[g] ? proc_gpio_out[g] : sp_drive[g]; // RULE_05 RULE_06 RULE_07
      assign poe_d[g] = pin_func_q[g] ? 1'b1 : sp_oe[g]; // RULE_08
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      po_q <= '0;
      poe_q <= '0;
    end else begin
      po_q <= po_d;
      poe_q <= poe_d;
    end
  end
  assign pin_o = po_q;
  assign pin_oe = poe_q;
  assign proc_gpio_in = pin_in_q & pin_func_q;
  assign sp_data_in = pin_in_q[arcc_pkg::PIN_DATA_IN] &&
                      !pin_func_q[arcc_pkg::PIN_DATA_IN]; // RULE_08

  // ===========================================
  // Checks
  logic [15:0] gap_q;
  logic gap_ok_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= '0;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q <= (p_hit || wr_port) ? 16'h0001 : gap_q + 16'h0001;
      gap_ok_q <= wr_port ? 1'b0 : (p_hit ? 1'b1 : gap_ok_q);
    end
  end

  property p_proc_path;
    @(posedge clk) disable iff (!rstn)
    (route_q == 4'h0) |-> (fin_valid == proc_valid) && (fin_data[FW-1 -: 2] == proc_slot);
  endproperty
  a_proc_path: assert property (p_proc_path) else $error("processor path broken"); // RULE_01

  property p_straight;
    @(posedge clk) disable iff (!rstn)
    (route_q[0] && !route_q[3] && adc_valid) |->
      fin_valid && (fin_data[FW-1 -: 2] == route_q[2:1]) &&
      (fin_data[2*SAMPLE_W-1 -: SAMPLE_W] == adc_left);
  endproperty
  a_straight: assert property (p_straight) else $error("straight route wrong"); // RULE_02

  property p_swap;
    @(posedge clk) disable iff (!rstn)
    (route_q[0] && route_q[3] && adc_valid) |->
      (fin_data[2*SAMPLE_W-1 -: SAMPLE_W] == adc_right) && (fin_data[SAMPLE_W-1:0] == adc_left);
  endproperty
  a_swap: assert property (p_swap) else $error("swapped route wrong"); // RULE_03

  property p_pin_gpio;
    @(posedge clk) disable iff (!rstn)
    (pin_func_q[2] && $stable(pin_func_q)) |=> pin_oe[2] && (pin_o[2] == $past(proc_gpio_out[2]));
  endproperty
  a_pin_gpio: assert property (p_pin_gpio) else $error("gpio pin not driven"); // RULE_05

  property p_frame_clk;
    @(posedge clk) disable iff (!rstn)
    // Sampled rstn skips the release edge, where the pin enables still hold reset
    (rstn && !pin_func_q[3] && $stable(pin_func_q)) |=>
      pin_oe[3] && (pin_o[3] == $past(sp_frame_clk));
  endproperty
  a_frame_clk: assert property (p_frame_clk) else $error("frame clock pin wrong"); // RULE_06

  property p_data_out;
    @(posedge clk) disable iff (!rstn)
    (rstn && !pin_func_q[1] && $stable(pin_func_q)) |=> (pin_o[1] == $past(sp_data_out));
  endproperty
  a_data_out: assert property (p_data_out) else $error("data out pin wrong"); // RULE_07

  property p_data_in;
    @(posedge clk) disable iff (!rstn)
    pin_func_q[0] |-> !sp_data_in ##1 (!pin_func_q[0] || pin_oe[0]);
  endproperty
  a_data_in: assert property (p_data_in) else $error("data in pin wrong"); // RULE_08

  property p_run;
    @(posedge clk) disable iff (!rstn)
    proc_frame_start |-> run_q && q_tick && !$past(proc_frame_start);
  endproperty
  a_run: assert property (p_run) else $error("frame pulse without run"); // RULE_09 RULE_10

  property p_none;
    @(posedge clk) disable iff (!rstn)
    (frame_q >= arcc_pkg::FRAME_NONE_MIN) |-> !proc_frame_start;
  endproperty
  a_none: assert property (p_none) else $error("frame pulse at rate none"); // RULE_15

  property p_port_gap;
    @(posedge clk) disable iff (!rstn)
    (p_hit && gap_ok_q) |-> (gap_q == 16'(pdiv * QTR_CYCLES));
  endproperty
  a_port_gap: assert property (p_port_gap) else $error("port rate period wrong"); // RULE_13
endmodule // arcc_core
`default_nettype wire

/* File: verif/audio_route_core_control_bench.sv */
/*
  Self-checking bench for the audio route core control block.
  Assumes arcc_pkg and arcc_core compiled first; the bench drives every
  port itself and models the shared pins' wire levels.
*/
`default_nettype none
module audio_route_core_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================
  // Signals
  localparam int QC = 4;
  localparam int SW = 24;
  localparam logic [15:0] OFS [5] = '{arcc_pkg::OFS_FRAME_RATE, arcc_pkg::OFS_CAPTURE_ROUTE,
    arcc_pkg::OFS_PIN_FUNC, arcc_pkg::OFS_PROC_RUN, arcc_pkg::OFS_PORT_RATE};
  localparam logic [7:0] MSK [5] = '{8'h0F, 8'h0F, 8'h0F, 8'h01, 8'h07};
  localparam int QT [8] = '{4, 24, 16, 12, 8, 6, 2, 0};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic adc_valid = 1'b0;
  logic [SW-1:0] adc_left = '0;
  logic [SW-1:0] adc_right = '0;
  logic proc_valid = 1'b0;
  logic [1:0] proc_slot = 2'h0;
  logic [SW-1:0] proc_left = '0;
  logic [SW-1:0] proc_right = '0;
  logic [3:0] proc_gpio_out = 4'h0;
  logic out_ready = 1'b1;
  logic sp_frame_clk = 1'b0;
  logic sp_bit_clk = 1'b0;
  logic sp_data_out = 1'b0;
  logic [3:0] ext_pin = 4'h0;
  logic [7:0] reg_rdata;
  logic adc_ready, proc_run, proc_frame_start, proc_in_valid, proc_ready;
  logic [SW-1:0] proc_in_left, proc_in_right, out_left, out_right;
  logic [3:0] proc_gpio_in, pin_o, pin_oe;
  logic out_valid, port_tick, sp_data_in;
  logic [1:0] out_slot;
  wire logic [3:0] pin_i;
  logic [49:0] exp_out [$];
  logic [7:0] exp_reg [$];
  logic rd_pend = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int np = 0;
  int nf = 0;
  // Undriven pads follow the bench; driven pads follow the block
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_pin);
  always #12.5 clk = ~clk;
  arcc_core #(.SAMPLE_W(SW), .QTR_CYCLES(QC)) dut (.clk, .rstn, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .adc_valid, .adc_ready, .adc_left, .adc_right,
    .proc_run, .proc_frame_start, .proc_in_valid, .proc_in_left, .proc_in_right,
    .proc_valid, .proc_ready, .proc_slot, .proc_left, .proc_right, .proc_gpio_out,
    .proc_gpio_in, .out_valid, .out_ready, .out_slot, .out_left, .out_right, .port_tick,
    .sp_frame_clk, .sp_bit_clk, .sp_data_out, .sp_data_in, .pin_i, .pin_o, .pin_oe);
  // ===========================================
  // Compare and report
  task automatic bad(input logic [49:0] g, input logic [49:0] e);
    failures++;
    $display("mismatch at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) bad(50'(g), 50'(e));
  endtask
  task automatic cmp_word(input logic [49:0] g, input logic [49:0] e);
    n_checks++;
    if (g !== e) bad(g, e);
  endtask
  task automatic cmp_val(input logic [49:0] g, input logic [49:0] e);
    n_checks++;
    if (g !== e) bad(g, e);
  endtask
  // Tick counts may be off by one: a write restarts counters mid-phase
  task automatic cmp_cnt(input int g, input int e);
    n_checks++;
    if (g > e + 1 || g + 1 < e || (e == 0 && g != 0)) bad(50'(g), 50'(e));
  endtask
  task automatic wrap_up();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up();
    failures++;
    wrap_up();
  endtask
  // ===========================================
  // Watcher: pops the oldest note when a result shows
  always @(posedge clk) begin
    if (rd_pend) begin
      if (exp_reg.size() == 0) bad(50'(reg_rdata), '0);
      else cmp_reg(reg_rdata, exp_reg.pop_front());
    end
    rd_pend <= reg_rd & rstn;
    if (out_valid === 1'b1 && out_ready) begin
      if (exp_out.size() == 0) bad({out_slot, out_left, out_right}, '0);
      else cmp_word({out_slot, out_left, out_right}, exp_out.pop_front());
    end
    if (proc_frame_start === 1'b1) nf++;
    if (port_tick === 1'b1) np++;
  end
  // ===========================================
  // Drivers: wr and rd wait for a rising edge, the rest are entered just after one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_reg.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic send(input logic [SW-1:0] l, input logic [SW-1:0] r);
    int i;
    adc_valid <= 1'b1;
    adc_left <= l;
    adc_right <= r;
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      if (adc_ready === 1'b1) break;
    end
    if (i == 200) give_up();
    @(posedge clk);
  endtask
  task automatic presult(input logic [1:0] s, input logic [SW-1:0] l, input logic [SW-1:0] r);
    int i;
    proc_valid <= 1'b1;
    proc_slot <= s;
    proc_left <= l;
    proc_right <= r;
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      if (proc_ready === 1'b1) break;
    end
    if (i == 200) give_up();
    exp_out.push_back({s, l, r});
    @(posedge clk);
    proc_valid <= 1'b0;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 400 && exp_out.size() != 0; i++) @(posedge clk);
    if (i == 400) give_up();
  endtask
  task automatic count(input int n, output int dp, output int df);
    int p0;
    int f0;
    @(negedge clk);
    p0 = np;
    f0 = nf;
    repeat (n) @(negedge clk);
    dp = np - p0;
    df = nf - f0;
  endtask
  // ===========================================
  // Main sequence
  initial begin
    logic [SW-1:0] l;
    logic [SW-1:0] r;
    logic [3:0] f4;
    int dp;
    int df;
    void'($urandom(27));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Pin enables leave reset on the first edge after release
    @(posedge clk);
    @(negedge clk);
    cmp_val(50'(pin_oe), 50'(4'hE));
    for (int k = 0; k < 5; k++) begin
      rd(OFS[k], 8'h00);
      wr(OFS[k], 8'hFF);
      rd(OFS[k], MSK[k]);
    end
    wr(16'h40F5, 8'hFF);
    rd(16'h40F5, 8'h00);
    wr(arcc_pkg::OFS_FRAME_RATE, 8'h7F);
    for (int k = 1; k < 5; k++) wr(OFS[k], 8'h00);
    $display("test registers done");
    // Odd codes only: even nonzero codes are left alone
    for (int c = 1; c < 16; c += 2) begin
      wr(arcc_pkg::OFS_CAPTURE_ROUTE, 8'(c));
      repeat (2) begin
        l = SW'($urandom());
        r = SW'($urandom());
        exp_out.push_back({2'(c >> 1), c[3] ? {r, l} : {l, r}});
        send(l, r);
      end
      adc_valid <= 1'b0;
      drain();
    end
    // Stall the far side until the buffer refuses
    out_ready <= 1'b0;
    repeat (8) begin
      l = SW'($urandom());
      r = SW'($urandom());
      exp_out.push_back({2'h3, r, l});
      send(l, r);
    end
    adc_valid <= 1'b0;
    @(negedge clk);
    cmp_val(50'(adc_ready), 50'(1'b0));
    @(posedge clk);
    out_ready <= 1'b1;
    drain();
    $display("test bypass done");
    wr(arcc_pkg::OFS_CAPTURE_ROUTE, 8'h00);
    repeat (4) begin
      l = SW'($urandom());
      r = SW'($urandom());
      send(l, r);
      adc_valid <= 1'b0;
      @(negedge clk);
      cmp_val(50'({proc_in_valid, proc_in_left, proc_in_right}), 50'({1'b1, l, r}));
      @(posedge clk);
      presult(2'($urandom()), SW'($urandom()), SW'($urandom()));
    end
    drain();
    $display("test processor route done");
    for (int f = 0; f < 16; f++) begin
      f4 = 4'(f);
      wr(arcc_pkg::OFS_PIN_FUNC, 8'(f));
      proc_gpio_out <= 4'($urandom());
      ext_pin <= 4'($urandom());
      {sp_frame_clk, sp_bit_clk, sp_data_out} <= 3'($urandom());
      repeat (6) @(posedge clk);
      @(negedge clk);
      cmp_val(50'(pin_oe), 50'({3'h7, f4[0]}));
      cmp_val(50'(pin_o & {3'h7, f4[0]}), 50'(((proc_gpio_out & f4) |
        ({sp_frame_clk, sp_bit_clk, sp_data_out, 1'b0} & ~f4)) & {3'h7, f4[0]}));
      cmp_val(50'(proc_gpio_in), 50'(proc_gpio_out & f4));
      cmp_val(50'(sp_data_in), 50'(~f4[0] & ext_pin[0]));
    end
    wr(arcc_pkg::OFS_PIN_FUNC, 8'h00);
    $display("test pins done");
    for (int c = 0; c < 8; c++) begin
      wr(arcc_pkg::OFS_PORT_RATE, 8'(c));
      count(384, dp, df);
      cmp_cnt(dp, QT[c] != 0 ? 384 / (QT[c] * QC) : 0);
    end
    wr(arcc_pkg::OFS_PORT_RATE, 8'h00);
    $display("test port rate done");
    wr(arcc_pkg::OFS_FRAME_RATE, 8'h01);
    wr(arcc_pkg::OFS_PROC_RUN, 8'h01);
    count(320, dp, df);
    cmp_val(50'(proc_run), 50'(1'b1));
    cmp_cnt(df, 320 / (4 * QC));
    wr(arcc_pkg::OFS_FRAME_RATE, 8'h7F);
    count(200, dp, df);
    cmp_cnt(df, 0);
    // Settle time shortened from the real stop delay to keep the run brief
    wr(arcc_pkg::OFS_PROC_RUN, 8'h00);
    @(negedge clk);
    cmp_val(50'(proc_run), 50'(1'b0));
    wr(arcc_pkg::OFS_FRAME_RATE, 8'h09);
    count(100, dp, df);
    cmp_cnt(df, 0);
    wr(arcc_pkg::OFS_PROC_RUN, 8'h01);
    count(160, dp, df);
    cmp_cnt(df, 160 / QC);
    wr(arcc_pkg::OFS_PORT_RATE, 8'h04);
    wr(arcc_pkg::OFS_FRAME_RATE, 8'h08);
    count(320, dp, df);
    cmp_cnt(df, 320 / (8 * QC));
    cmp_cnt(dp, 320 / (8 * QC));
    $display("test processor run done");
    wrap_up();
  end
endmodule // audio_route_core_control_bench
`default_nettype wire
